//--- hdl/adcps_defines.vh
// Purpose: Register map, field positions and reset values of the
//          priority select / compare block.
// Assumes: 32-bit register port, byte addresses, one word per register.
// Notes:   Included by the design files by bare name.
`ifndef ADCPS_DEFINES_VH
`define ADCPS_DEFINES_VH

// Register byte offsets
`define ADCPS_OFF_RESULT 8'h00
`define ADCPS_OFF_CHSEL 8'h04
`define ADCPS_OFF_CMPVAL 8'h08
`define ADCPS_OFF_CMPCTL 8'h0c
`define ADCPS_OFF_STS_HI 8'h10
`define ADCPS_OFF_STS_LO 8'h14
`define ADCPS_OFF_CONV 8'h18

// Result word layout
`define ADCPS_RES_VAL_HI 31
`define ADCPS_RES_VAL_LO 20
`define ADCPS_RES_ENTRY_INVALID_FLAG 12
`define ADCPS_RES_CAUSE_HI 10
`define ADCPS_RES_CAUSE_LO 8
`define ADCPS_RES_CH_HI 4
`define ADCPS_RES_CH_LO 0

// Start cause codes
`define ADCPS_CAUSE_SW 3'h1
`define ADCPS_CAUSE_TMR 3'h2
`define ADCPS_CAUSE_EXT 3'h4

// Channel select byte
`define ADCPS_CHSEL_L2_HI 7
`define ADCPS_CHSEL_L2_LO 3
`define ADCPS_CHSEL_L1_HI 2
`define ADCPS_CHSEL_L1_LO 0

// Compare value and control
`define ADCPS_CMPVAL_HI 31
`define ADCPS_CMPVAL_LO 22
`define ADCPS_CMP_EN 7
`define ADCPS_CMP_COND 6
`define ADCPS_CMP_ALL 5
`define ADCPS_CMP_CH_HI 4
`define ADCPS_CMP_CH_LO 0

// Converter control/status word
`define ADCPS_CONV_CMPF 0
`define ADCPS_CONV_EMPTY 1
`define ADCPS_CONV_FULL 2
`define ADCPS_CONV_OVR 3
`define ADCPS_CONV_CNT_HI 6
`define ADCPS_CONV_CNT_LO 4

// Read sizes
`define ADCPS_SIZE_BYTE 2'h0
`define ADCPS_SIZE_HALF 2'h1
`define ADCPS_SIZE_WORD 2'h2

// Reset values
`define ADCPS_RST_CHSEL 8'h00
`define ADCPS_RST_CMPCTL 8'h00
`define ADCPS_RST_CMPVAL 10'h000
`define ADCPS_RST_STS 32'h00000000

// Channels built into this product, one bit per channel
`define ADCPS_CHAN_IMPL 32'h0000ffff

// Store geometry
`define ADCPS_FIFO_DEPTH 4
`define ADCPS_ENTRY_W 20

`endif

//--- hdl/adcps_fifo_mem.v
// Purpose: Four-entry storage for priority results, registered read.
// Assumes: One write and one read address per cycle.
// Notes:   A write to the address being read shows on the same edge as the write.
`timescale 1ns/100ps
`include "adcps_defines.vh"

module adcps_fifo_mem (
  input wire core_clk, // Block clock
  input wire wr_en, // Write strobe
  input wire [1:0] wr_addr, // Write address
  input wire [19:0] wr_data, // Entry to store
  input wire [1:0] rd_addr, // Read address
  output reg [19:0] rd_data // Registered entry
);

  reg [19:0] mem [0:`ADCPS_FIFO_DEPTH-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Write-through avoids a stale head when the store was empty
  always @(posedge core_clk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

//--- hdl/adcps_top.v
// Purpose: Priority result store, channel selection, window compare
//          and per-channel sampling-time choice around a 12-bit ADC.
// Assumes: Conversion engine on core_clk hands in finished results.
// Notes:   Register reads answer one cycle after the read strobe.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "adcps_defines.vh"

module adcps_top (
  input wire core_clk, // 125 MHz block clock
  input wire rst, // Asynchronous reset, active high
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe, one cycle
  input wire reg_rd, // Read strobe, one cycle
  input wire [1:0] reg_size, // Read size: byte, half, word
  output reg [31:0] reg_rdata, // Read data, cycle after strobe
  input wire conv_done, // Conversion finished, one cycle
  input wire [11:0] conv_value, // Finished conversion value
  input wire [4:0] conv_channel, // Channel of finished conversion
  input wire conv_prio, // Finished conversion was priority
  input wire [2:0] conv_cause, // Start cause of priority result
  input wire [4:0] sample_channel, // Channel now being sampled
  output wire [4:0] level2_channel_field, // Software/timer channel
  output wire [2:0] level1_channel_field, // External trigger channel
  output wire [4:0] ext_trigger_channel, // Level 1 channel, widened
  output wire use_setting_b, // Sampling channel uses setting b
  output wire [31:0] channel_sample_time_bits, // All selection bits
  output wire compare_event_flag, // Sticky compare flag
  output wire fifo_empty, // Priority store empty
  output wire fifo_full // Priority store full
);

  // Channel implemented in this product
  // Unbuilt channels fail here, so a field naming one keeps its old value
  function chan_ok;
    input [4:0] ch;
    reg [31:0] impl;
    begin
      impl = `ADCPS_CHAN_IMPL;
      chan_ok = impl[ch];
    end
  endfunction

  // Register decode on the word address; every lane of a word hits it
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      // Byte and half reads of the result word land on offsets 0 to 3
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  reg [7:0] chsel_q;
  reg [7:0] chsel_d;
  reg [9:0] cmpval_q;
  reg [7:0] cmpctl_q;
  reg [7:0] cmpctl_d;
  reg [31:0] sts_q;
  reg [31:0] sts_d;
  reg cmpf_q;
  reg ovr_q;
  reg [1:0] wr_ptr_q;
  reg [1:0] rd_ptr_q;
  reg [2:0] count_q;
  reg [31:0] reg_rdata_d;

  wire [19:0] head_entry;
  wire [11:0] head_value;
  wire [2:0] head_cause;
  wire [4:0] head_channel;
  wire [31:0] result_word;
  wire res_read;
  wire pop;
  wire push;
  wire store_full;
  wire store_empty;
  wire [1:0] rd_ptr_d;
  wire [4:0] entry_channel;
  wire [19:0] entry_data;
  wire [9:0] cmp_bits;
  wire cmp_target;
  wire cmp_cond;
  wire cmp_hit;
  wire cmpf_clr;
  wire [31:0] impl_mask;
  wire [7:0] reg_word_addr;

  // Count is three bits wide, so the depth constant is cut to match
  localparam [2:0] full_count = `ADCPS_FIFO_DEPTH;

  assign impl_mask = `ADCPS_CHAN_IMPL;
  // Four entries fill the store; one more result is an overrun
  assign store_full = (count_q == full_count);
  assign store_empty = (count_q == 3'h0);
  assign reg_word_addr = {reg_addr[7:2], 2'h0};

  // Result word reads and the pop decision
  assign res_read = reg_rd && hit(reg_addr, `ADCPS_OFF_RESULT);

  // Lanes sit little-endian: top byte at offset 3, upper half at 2
  assign pop = res_read && !store_empty &&
    ((reg_size == `ADCPS_SIZE_WORD) ||
     ((reg_size == `ADCPS_SIZE_HALF) && (reg_addr[1:0] == 2'h2)) ||
     ((reg_size == `ADCPS_SIZE_BYTE) && (reg_addr[1:0] == 2'h3)));

  // Priority results only; a full store drops the new one
  assign push = conv_done && conv_prio && !store_full;

  // External trigger results always come from channels 0 to 7
  assign entry_channel = conv_cause[2] ?
    {2'h0, conv_channel[2:0]} : conv_channel;

  // Cause stored as given, so 3'h3 survives a shared start
  assign entry_data = {conv_value, conv_cause, entry_channel};

  // Read address runs one step ahead so the head is never stale
  assign rd_ptr_d = pop ? (rd_ptr_q + 2'h1) : rd_ptr_q;

  adcps_fifo_mem u_mem (
    .core_clk(core_clk),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(entry_data),
    .rd_addr(rd_ptr_d),
    .rd_data(head_entry)
  );

  assign head_value = head_entry[19:8];
  assign head_cause = head_entry[7:5];
  assign head_channel = head_entry[4:0];

  // Empty store presents the invalid flag and zero fields
  assign result_word = store_empty ?
    (32'h00000001 << `ADCPS_RES_ENTRY_INVALID_FLAG) :
    {head_value,
     7'h00,
     1'b0,
     1'b0,
     head_cause,
     3'h0,
     head_channel};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 3'h0;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (push && !pop) begin
        count_q <= count_q + 3'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 3'h1;
      end
    end
  end

  // Overrun: a priority result arrived while the store was full
  // Cleared like the compare flag; a new overrun beats the clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (conv_done && conv_prio && store_full) begin
      ovr_q <= 1'b1;
    end else if (reg_wr && hit(reg_addr, `ADCPS_OFF_CONV) &&
                 !reg_wdata[`ADCPS_CONV_OVR]) begin
      ovr_q <= 1'b0;
    end
  end

  // Channel select: each field only takes a built channel
  always @* begin
    chsel_d = chsel_q;
    if (reg_wr && hit(reg_addr, `ADCPS_OFF_CHSEL)) begin
      if (chan_ok(reg_wdata[7:3])) begin
        chsel_d[7:3] = reg_wdata[7:3];
      end
      if (chan_ok({2'h0, reg_wdata[2:0]})) begin
        chsel_d[2:0] = reg_wdata[2:0];
      end
    end
  end

  // Compare control: channel field guarded like the channel select
  always @* begin
    cmpctl_d = cmpctl_q;
    if (reg_wr && hit(reg_addr, `ADCPS_OFF_CMPCTL)) begin
      cmpctl_d[7:5] = reg_wdata[7:5];
      if (chan_ok(reg_wdata[4:0])) begin
        cmpctl_d[4:0] = reg_wdata[4:0];
      end
    end
  end

  // Sampling-time selection, two 16-bit halves
  always @* begin
    sts_d = sts_q;
    if (reg_wr && hit(reg_addr, `ADCPS_OFF_STS_HI)) begin
      sts_d[31:16] = reg_wdata[15:0];
    end
    if (reg_wr && hit(reg_addr, `ADCPS_OFF_STS_LO)) begin
      sts_d[15:0] = reg_wdata[15:0];
    end
    sts_d = sts_d & impl_mask;
  end

  // Writes during an active conversion are software's to avoid
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chsel_q <= `ADCPS_RST_CHSEL;
      cmpctl_q <= `ADCPS_RST_CMPCTL;
      cmpval_q <= `ADCPS_RST_CMPVAL;
      sts_q <= `ADCPS_RST_STS;
    end else begin
      chsel_q <= chsel_d;
      cmpctl_q <= cmpctl_d;
      sts_q <= sts_d;
      if (reg_wr && hit(reg_addr, `ADCPS_OFF_CMPVAL)) begin
        // Bits 21:0 are not stored
        cmpval_q <= reg_wdata[`ADCPS_CMPVAL_HI:`ADCPS_CMPVAL_LO];
      end
    end
  end

  assign level2_channel_field = chsel_q[`ADCPS_CHSEL_L2_HI:
                                        `ADCPS_CHSEL_L2_LO];
  assign level1_channel_field = chsel_q[`ADCPS_CHSEL_L1_HI:
                                        `ADCPS_CHSEL_L1_LO];
  assign ext_trigger_channel = {2'h0, level1_channel_field};

  // Per-channel sampling time choice
  assign channel_sample_time_bits = sts_q;
  assign use_setting_b = sts_q[sample_channel];

  // Window compare on the upper ten result bits
  // Every finished conversion is compared, priority or not
  assign cmp_bits = conv_value[11:2];
  assign cmp_target = cmpctl_q[`ADCPS_CMP_ALL] ||
    (conv_channel == cmpctl_q[`ADCPS_CMP_CH_HI:`ADCPS_CMP_CH_LO]);
  assign cmp_cond = cmpctl_q[`ADCPS_CMP_COND] ?
    (cmp_bits >= cmpval_q) : (cmp_bits < cmpval_q);
  assign cmp_hit = conv_done && cmpctl_q[`ADCPS_CMP_EN] &&
    cmp_target && cmp_cond;

  // Writing zero clears; a hit in the same cycle wins
  assign cmpf_clr = reg_wr && hit(reg_addr, `ADCPS_OFF_CONV) &&
    !reg_wdata[`ADCPS_CONV_CMPF];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmpf_q <= 1'b0;
    end else if (cmp_hit) begin
      cmpf_q <= 1'b1;
    end else if (cmpf_clr) begin
      cmpf_q <= 1'b0;
    end
  end

  assign compare_event_flag = cmpf_q;
  assign fifo_empty = store_empty;
  assign fifo_full = store_full;

  // Read mux; unmapped addresses and reserved bits read zero
  always @* begin
    reg_rdata_d = 32'h00000000;
    // Lane reads get the whole word; the master keeps its own lanes
    case (reg_word_addr)
      `ADCPS_OFF_RESULT: begin
        reg_rdata_d = result_word;
      end
      `ADCPS_OFF_CHSEL: begin
        reg_rdata_d = {24'h000000, chsel_q};
      end
      `ADCPS_OFF_CMPVAL: begin
        reg_rdata_d = {cmpval_q, 22'h000000};
      end
      `ADCPS_OFF_CMPCTL: begin
        reg_rdata_d = {24'h000000, cmpctl_q};
      end
      `ADCPS_OFF_STS_HI: begin
        reg_rdata_d = {16'h0000, sts_q[31:16]};
      end
      `ADCPS_OFF_STS_LO: begin
        reg_rdata_d = {16'h0000, sts_q[15:0]};
      end
      `ADCPS_OFF_CONV: begin
        reg_rdata_d = {25'h0000000, count_q, ovr_q,
                       store_full, store_empty, cmpf_q};
      end
      default: begin
        reg_rdata_d = 32'h00000000;
      end
    endcase
  end

  // Data stands only in the cycle after the strobe
  // Zero outside the answer cycle keeps an idle bus quiet
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

//--- verif/adcps_top_assertions.sv
// Purpose: Port-level checks of the priority select / compare block.
// Assumes: Single clock domain, asynchronous active-high reset.
// Notes:   Bound to every adcps_top instance.
`timescale 1ns/100ps

module adcps_top_chk (
  input wire core_clk, // Block clock
  input wire rst, // Reset, active high
  input wire [7:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata, // Read data
  input wire conv_done, // Conversion finished
  input wire conv_prio, // Priority conversion
  input wire [4:0] sample_channel, // Channel being sampled
  input wire [4:0] level2_channel_field, // Software/timer channel
  input wire [2:0] level1_channel_field, // External trigger channel
  input wire [4:0] ext_trigger_channel, // Level 1 channel, widened
  input wire use_setting_b, // Setting b chosen
  input wire [31:0] channel_sample_time_bits, // Selection bits
  input wire compare_event_flag, // Sticky compare flag
  input wire fifo_empty, // Store empty
  input wire fifo_full // Store full
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Read data only stand in the cycle after a strobe
  a_rdata_only_after: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_ext_ch_low: assert property (
    ext_trigger_channel == {2'b00, level1_channel_field})
    else $error("external trigger channel beyond seven");
  a_sel_unbuilt_zero: assert property (
    channel_sample_time_bits[31:16] == 16'h0000)
    else $error("selection bit set for unbuilt channel");
  a_setting_b_map: assert property (
    use_setting_b == channel_sample_time_bits[sample_channel])
    else $error("sampling setting does not follow channel bit");
  a_flag_cause: assert property (
    $rose(compare_event_flag) |-> $past(conv_done))
    else $error("compare flag set without a conversion");
  // Any lane of the status word clears the flag with bit 0 low
  a_flag_sticky: assert property (
    compare_event_flag &&
    !(reg_wr && (reg_addr[7:2] == 6'h06) && !reg_wdata[0])
    |=> compare_event_flag)
    else $error("compare flag dropped without clear");
  a_push_nonempty: assert property (
    conv_done && conv_prio |=> !fifo_empty)
    else $error("store empty after priority push");
  a_empty_full_excl: assert property (
    !(fifo_empty && fifo_full))
    else $error("store empty and full together");
  a_l2_built: assert property (
    level2_channel_field < 5'h10)
    else $error("level 2 field holds unbuilt channel");
endmodule

bind adcps_top adcps_top_chk chk (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
  .conv_prio(conv_prio), .sample_channel(sample_channel),
  .level2_channel_field(level2_channel_field),
  .level1_channel_field(level1_channel_field),
  .ext_trigger_channel(ext_trigger_channel), .use_setting_b(use_setting_b),
  .channel_sample_time_bits(channel_sample_time_bits),
  .compare_event_flag(compare_event_flag), .fifo_empty(fifo_empty),
  .fifo_full(fifo_full));

//--- verif/tb_top.sv
// Purpose: Register-level tests of the priority select / compare block.
// Assumes: Read data stand in the cycle after the read strobe.
// Notes:   Popping byte and half reads compare only their lanes, status reads only their low bits; the others compare the whole word.
`timescale 1ns/100ps

module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] reg_size = 2'h2;
  wire [31:0] reg_rdata;
  logic conv_done = 1'b0;
  logic [11:0] conv_value = 12'h000;
  logic [4:0] conv_channel = 5'h00;
  logic conv_prio = 1'b0;
  logic [2:0] conv_cause = 3'h0;
  logic [4:0] sample_channel = 5'h00;
  wire [4:0] level2_channel_field;
  wire [2:0] level1_channel_field;
  wire [4:0] ext_trigger_channel;
  wire use_setting_b;
  wire [31:0] channel_sample_time_bits;
  wire compare_event_flag;
  wire fifo_empty;
  wire fifo_full;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rdv;
  logic [11:0] tv[5] = '{12'habc, 12'h123, 12'h456, 12'hfed, 12'h777};
  logic [4:0] tc[5] = '{5'd9, 5'd15, 5'd2, 5'd13, 5'd1};
  logic [2:0] ta[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
  // Compare cases: control, channel, value, expected flag
  logic [31:0] cv[7] = '{32'h2000fff0, 32'ha0003fc1, 32'ha0004000,
    32'he0004001, 32'he0003ff0, 32'hc304fff0, 32'hc303fff1};

  adcps_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_size(reg_size), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_value(conv_value), .conv_channel(conv_channel),
    .conv_prio(conv_prio), .conv_cause(conv_cause),
    .sample_channel(sample_channel),
    .level2_channel_field(level2_channel_field),
    .level1_channel_field(level1_channel_field),
    .ext_trigger_channel(ext_trigger_channel),
    .use_setting_b(use_setting_b),
    .channel_sample_time_bits(channel_sample_time_bits),
    .compare_event_flag(compare_event_flag), .fifo_empty(fifo_empty),
    .fifo_full(fifo_full));

  always #4 core_clk = ~core_clk;

  function automatic logic [31:0] ew(input logic [11:0] v,
    input logic [2:0] ca, input logic [4:0] ch);
    ew = {v, 9'h000, ca, 3'h0, ca[2] ? {2'b00, ch[2:0]} : ch};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] s);
    @(posedge core_clk);
    reg_addr <= a;
    reg_size <= s;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  task automatic conv(input logic [11:0] v, input logic [4:0] ch,
    input logic p, input logic [2:0] ca);
    @(posedge core_clk);
    conv_value <= v;
    conv_channel <= ch;
    conv_prio <= p;
    conv_cause <= ca;
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h04, 2'h2);
    chk(rdv, 32'h0);
    rd(8'h0c, 2'h2);
    chk(rdv, 32'h0);
    rd(8'h00, 2'h2);
    chk(rdv, 32'h00001000);
    wr(8'h04, 32'h7a);
    #1 rdv = {24'h0, level2_channel_field, level1_channel_field};
    chk(rdv, 32'h7a);
    // Level 2 channel 16 is not built, level 1 still updates
    wr(8'h04, 32'h85);
    rd(8'h04, 2'h2);
    chk(rdv, 32'h7d);
    chk(ext_trigger_channel, 32'h5);
    for (int i = 0; i < 5; i++) conv(tv[i], tc[i], 1'b1, ta[i]);
    #1 chk(fifo_full, 32'h1);
    rd(8'h18, 2'h2);
    chk(rdv[6:0], 32'h4c);
    // Lane reads that must not pop still show the head entry
    rd(8'h01, 2'h0);
    chk(rdv, ew(tv[0], ta[0], tc[0]));
    rd(8'h00, 2'h1);
    chk(rdv, ew(tv[0], ta[0], tc[0]));
    rd(8'h00, 2'h2);
    chk(rdv, ew(tv[0], ta[0], tc[0]));
    rd(8'h03, 2'h0);
    chk(rdv[31:24], {24'h0, tv[1][11:4]});
    rd(8'h02, 2'h1);
    chk(rdv[31:16], {16'h0, tv[2], 4'h0});
    rd(8'h00, 2'h2);
    chk(rdv, ew(tv[3], ta[3], tc[3]));
    #1 chk(fifo_empty, 32'h1);
    for (int i = 1; i < 4; i++) begin
      conv(12'h800, 5'd7, 1'b1, i[2:0]);
      rd(8'h00, 2'h2);
      chk(rdv, ew(12'h800, i[2:0], 5'd7));
    end
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 2'h2);
    chk(rdv, 32'hffc00000);
    wr(8'h08, {10'h100, 22'h0});
    for (int i = 0; i < 7; i++) begin
      wr(8'h0c, {24'h0, cv[i][31:24]});
      conv(cv[i][15:4], cv[i][20:16], 1'b0, 3'h1);
      rd(8'h18, 2'h2);
      chk(rdv[0], cv[i][0]);
      chk(compare_event_flag, cv[i][0]);
      wr(8'h18, 32'h0);
    end
    wr(8'h10, 32'hffffffff);
    wr(8'h14, 32'h0000a5a5);
    #1 chk(channel_sample_time_bits, 32'h0000a5a5);
    rd(8'h10, 2'h2);
    chk(rdv, 32'h0);
    // Upper channels are unbuilt and must pick setting a
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk);
      sample_channel <= i[4:0];
      #1 chk(use_setting_b, (32'ha5a5 >> i) & 32'h1);
    end
    rd(8'h1c, 2'h2);
    chk(rdv, 32'h0);
    results();
  end
endmodule
